// ==== verilog/tpi_device.sv ====
// tpi_device.sv: touch-panel target end; bytes registers reached through a 16-bit pointer.
// assumes the master end on the same tpi_if; link logic runs on LINK_CLK, user side on CLK_SYS.
`timescale 1ns/1ps
`include "tpi_regs.svh"
module tpi_device import tpi_pkg::*; #(
  parameter int REG_AW = 8
) (
  // clocks and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        LINK_CLK,
  // bus
  tpi_if.dev               BUS,
  // register write notices
  output logic             WR_STROBE,
  output logic [15:0]      WR_ADDR,
  output logic [7:0]       WR_DATA,
  // status
  output logic             ADDR_ALT_SEL,
  output logic             LINK_BUSY
);
  // ---------------- link domain ----------------
  logic [1:0]     lrst_sync;  // system reset brought to the link clock
  logic           scl_s1;     // clock line first stage
  logic           scl_s2;     // clock line second stage
  logic           scl_d;      // clock line last value
  logic           sda_s1;     // data line first stage
  logic           sda_s2;     // data line second stage
  logic           sda_d;      // data line last value
  logic           rstn_s1;    // reset line first stage
  logic           rstn_s2;    // reset line second stage
  logic           rstn_d;     // reset line last value
  logic           int_s1;     // strap line first stage
  logic           int_s2;     // strap line second stage
  logic           alt_sel;    // alternate address pair chosen

  tpi_dev_state_t st;         // transfer state
  tpi_dev_state_t next_st;
  logic [3:0]     bitn;       // bit inside the byte slot
  logic [3:0]     next_bitn;
  logic [7:0]     sh;         // received bits
  logic [7:0]     next_sh;
  logic [7:0]     tx;         // bits still to send
  logic [7:0]     next_tx;
  logic [15:0]    ptr;        // register pointer
  logic [15:0]    next_ptr;
  logic           sda_oe;     // pull data low
  logic           next_sda_oe;
  logic           mem_we;     // store a written byte
  logic           busy;       // a transfer is under way, from its start until its stop or refusal
  logic           wr_tgl;     // flips on each stored byte
  logic [15:0]    wr_addr_l;  // location of the last stored byte
  logic [7:0]     wr_data_l;  // value of the last stored byte
  logic [7:0]     regs_mem [2**REG_AW];  // register bytes

  wire lrst    = lrst_sync[1];
  wire dev_rst = lrst | ~rstn_s2;

  // bus events, read only from second stages and their delayed copies
  wire scl_rise   = scl_s2 & ~scl_d;
  wire scl_fall   = ~scl_s2 & scl_d;
  wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_cond  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // address compare against the strapped pair
  wire [7:0] addr_w     = alt_sel ? `TPI_ADDR_ALT_W : `TPI_ADDR_PRI_W;
  wire [7:0] addr_r     = alt_sel ? `TPI_ADDR_ALT_R : `TPI_ADDR_PRI_R;
  wire       addr_match = sh == addr_w || sh == addr_r;
  wire [7:0] rd_byte    = regs_mem[ptr[REG_AW-1:0]];

  assign BUS.d_sda_o  = 1'b0;
  assign BUS.d_sda_oe = sda_oe;

  // reset bridge into the link clock
  always_ff @(posedge LINK_CLK) begin
    lrst_sync <= {lrst_sync[0], RST};
  end

  // pin synchronisers and edge history
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
      {rstn_s1, rstn_s2, rstn_d} <= 3'h0;
      {int_s1, int_s2} <= 2'h0;
    end else begin
      scl_s1  <= BUS.scl;
      scl_s2  <= scl_s1;
      scl_d   <= scl_s2;
      sda_s1  <= BUS.sda;
      sda_s2  <= sda_s1;
      sda_d   <= sda_s2;
      rstn_s1 <= BUS.m_rst_n;
      rstn_s2 <= rstn_s1;
      rstn_d  <= rstn_s2;
      int_s1  <= BUS.int_lvl;
      int_s2  <= int_s1;
    end
  end

  // strap caught when the reset line rises; survives the bus reset
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      alt_sel <= 1'b0;
    end else if (rstn_s2 && !rstn_d) begin
      alt_sel <= int_s2;
    end
  end

  // transfer decoding; acts only on what the master starts
  always_comb begin
    next_st     = st;
    next_bitn   = bitn;
    next_sh     = sh;
    next_tx     = tx;
    next_ptr    = ptr;
    next_sda_oe = sda_oe;
    mem_we      = 1'b0;
    if (start_cond) begin
      next_st     = D_ADDR;
      // one below zero: the clock fall that closes the start wraps it to bit zero
      next_bitn   = 4'hf;
      next_sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_st     = D_IDLE;
      next_sda_oe = 1'b0;
    end else if (st != D_IDLE) begin
      if (scl_rise) begin
        if (bitn != `TPI_ACK_BIT) begin
          next_sh = {sh[6:0], sda_s2};
        end else if (st == D_RDATA && sda_s2) begin
          next_st = D_IDLE;
        end
      end else if (scl_fall) begin
        if (bitn == `TPI_LSB_BIT) begin
          // eighth bit done: the ninth pulse carries the acknowledge
          next_bitn = `TPI_ACK_BIT;
          unique case (st)
            D_IDLE: next_st = D_IDLE;
            D_ADDR: begin
              if (addr_match) begin
                next_sda_oe = 1'b1;
              end else begin
                next_st = D_IDLE;
              end
            end
            D_PTRH: begin
              next_ptr    = {sh, ptr[7:0]};
              next_sda_oe = 1'b1;
            end
            D_PTRL: begin
              next_ptr    = {ptr[15:8], sh};
              next_sda_oe = 1'b1;
            end
            D_WDATA: begin
              mem_we      = 1'b1;
              next_ptr    = ptr + 16'h0001;
              next_sda_oe = 1'b1;
            end
            D_RDATA: next_sda_oe = 1'b0;  // master answers this slot
          endcase
        end else if (bitn == `TPI_ACK_BIT) begin
          // acknowledge slot over: pick the next byte
          next_bitn   = 4'h0;
          next_sda_oe = 1'b0;
          unique case (st)
            D_IDLE:  next_st = D_IDLE;
            D_ADDR:  next_st = sh[0] ? D_RDATA : D_PTRH;
            D_PTRH:  next_st = D_PTRL;
            D_PTRL:  next_st = D_WDATA;
            D_WDATA: next_st = D_WDATA;
            D_RDATA: next_st = D_RDATA;
          endcase
          if ((st == D_ADDR && sh[0]) || st == D_RDATA) begin
            next_tx     = {rd_byte[6:0], 1'b0};
            next_sda_oe = ~rd_byte[7];
            next_ptr    = ptr + 16'h0001;
          end
        end else begin
          next_bitn = bitn + 4'h1;
          if (st == D_RDATA) begin
            next_sda_oe = ~tx[7];
            next_tx     = {tx[6:0], 1'b0};
          end
        end
      end
    end
  end

  // transfer state registers
  always_ff @(posedge LINK_CLK) begin
    if (dev_rst) begin
      st     <= D_IDLE;
      bitn   <= 4'h0;
      sh     <= 8'h00;
      tx     <= 8'h00;
      ptr    <= 16'h0000;
      sda_oe <= 1'b0;
      busy   <= 1'b0;
    end else begin
      st     <= next_st;
      bitn   <= next_bitn;
      sh     <= next_sh;
      tx     <= next_tx;
      ptr    <= next_ptr;
      sda_oe <= next_sda_oe;
      busy   <= next_st != D_IDLE;
    end
  end

  // register bytes; contents survive a bus reset
  always_ff @(posedge LINK_CLK) begin
    if (mem_we) begin
      regs_mem[ptr[REG_AW-1:0]] <= sh;
    end
  end

  // write notice held stable and flagged by a toggle
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      wr_tgl    <= 1'b0;
      wr_addr_l <= 16'h0000;
      wr_data_l <= 8'h00;
    end else if (mem_we) begin
      wr_tgl    <= ~wr_tgl;
      wr_addr_l <= ptr;
      wr_data_l <= sh;
    end
  end

  // ---------------- system domain ----------------
  logic tgl_s1;   // toggle first stage
  logic tgl_s2;   // toggle second stage
  logic tgl_d;    // toggle last value
  logic alt_s1;   // strap choice first stage
  logic busy_s1;  // busy first stage

  // toggle edge becomes a one-cycle strobe with its data
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      {tgl_s1, tgl_s2, tgl_d} <= 3'h0;
      {alt_s1, ADDR_ALT_SEL}  <= 2'h0;
      {busy_s1, LINK_BUSY}    <= 2'h0;
      WR_STROBE <= 1'b0;
      WR_ADDR   <= 16'h0000;
      WR_DATA   <= 8'h00;
    end else begin
      tgl_s1       <= wr_tgl;
      tgl_s2       <= tgl_s1;
      tgl_d        <= tgl_s2;
      alt_s1       <= alt_sel;
      ADDR_ALT_SEL <= alt_s1;
      busy_s1      <= busy;
      LINK_BUSY    <= busy_s1;
      WR_STROBE    <= tgl_s2 ^ tgl_d;
      if (tgl_s2 ^ tgl_d) begin
        WR_ADDR <= wr_addr_l;
        WR_DATA <= wr_data_l;
      end
    end
  end
endmodule

// ==== verilog/tpi_regs.svh ====
// tpi_regs.svh: constants of the touch-panel two-wire target port and its master.
// assumes it is included by bare name from the package and the end modules.
`ifndef TPI_REGS_SVH
`define TPI_REGS_SVH

// bus address pairs, selected at power-on by the interrupt strap
`define TPI_ADDR_PRI_W 8'hba
`define TPI_ADDR_PRI_R 8'hbb
`define TPI_ADDR_ALT_W 8'h28
`define TPI_ADDR_ALT_R 8'h29

// bit positions inside one nine-pulse byte slot
`define TPI_LSB_BIT 4'h7
`define TPI_ACK_BIT 4'h8

// system clock period and fastest bus bit time
`define TPI_CLK_SYS_NS 40
`define TPI_MAX_KBPS 400
`define TPI_BIT_NS (1000000 / `TPI_MAX_KBPS)
// quarter bit as a least time, rounded up to whole system cycles
`define TPI_QTR_CYC ((`TPI_BIT_NS / 4 + `TPI_CLK_SYS_NS - 1) / `TPI_CLK_SYS_NS)

// power-on reset hold and strap hold after the reset release
`define TPI_POR_NS 100000
`define TPI_POR_CYC ((`TPI_POR_NS + `TPI_CLK_SYS_NS - 1) / `TPI_CLK_SYS_NS)

`endif

// ==== verilog/tpi_pkg.sv ====
// tpi_pkg.sv: state and step types of both ends of the touch-panel port.
// assumes tpi_regs.svh sits beside it.
package tpi_pkg;
  `include "tpi_regs.svh"

  // target-side transfer states
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_PTRH, D_PTRL, D_WDATA, D_RDATA} tpi_dev_state_t;

  // master-side bus states
  typedef enum logic [2:0] {H_POR, H_IDLE, H_START, H_BIT, H_STOP} tpi_host_state_t;

  // master-side byte being moved
  typedef enum logic [2:0] {S_AW, S_PH, S_PL, S_DW, S_AR, S_DR} tpi_step_t;
endpackage

// ==== verilog/tpi_if.sv ====
// tpi_if.sv: the two-wire bus plus reset and strap lines between master and target.
// assumes open-drain clock and data wires with pull-ups; their drivers only ever pull low.
`timescale 1ns/1ps
interface tpi_if;
  logic m_scl_o;   // master clock output value
  logic m_scl_oe;  // master drives the clock line
  logic m_sda_o;   // master data output value
  logic m_sda_oe;  // master drives the data line
  logic d_sda_o;   // target data output value
  logic d_sda_oe;  // target drives the data line
  logic m_rst_n;   // target reset, low active, from master
  logic m_int_o;   // strap value on the interrupt line
  logic m_int_oe;  // master drives the interrupt line
  logic scl;       // resolved clock level
  logic sda;       // resolved data level
  logic int_lvl;   // resolved interrupt line level

  // wired-and with pull-ups on clock and data; the interrupt line reads low when undriven
  assign scl     = ~(m_scl_oe & ~m_scl_o);
  assign sda     = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
  assign int_lvl = m_int_oe ? m_int_o : 1'b0;

  modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, m_rst_n, m_int_o, m_int_oe,
                input  scl, sda);
  modport dev  (output d_sda_o, d_sda_oe,
                input  scl, sda, m_rst_n, int_lvl);
endinterface

// ==== verilog/tpi_fifo2.sv ====
// tpi_fifo2.sv: two-entry buffer with valid and ready on both sides.
// assumes one clock for both sides and a synchronous active-high reset.
`timescale 1ns/1ps
module tpi_fifo2 import tpi_pkg::*; #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem [2];  // entry storage
  logic         wp;       // write slot
  logic         rp;       // read slot
  logic [1:0]   cnt;      // words held

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = cnt != 2'h2;
  assign out_valid = cnt != 2'h0;
  assign out_data  = mem[rp];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (rst) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      wp  <= wp ^ push;
      rp  <= rp ^ pop;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ==== verilog/tpi_host.sv ====
// tpi_host.sv: bus master end; makes the bus clock by dividing its own clock.
// assumes the target end on the same tpi_if and a user that issues one command at a time.
`timescale 1ns/1ps
`include "tpi_regs.svh"
module tpi_host import tpi_pkg::*; #(
  parameter int QTR_CYC = `TPI_QTR_CYC,
  parameter int POR_CYC = `TPI_POR_CYC
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // bus
  tpi_if.host              BUS,
  // power-on address choice
  input  wire logic        ADDR_ALT,
  // command
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire logic        CMD_READ,
  input  wire logic [15:0] CMD_PTR,
  input  wire logic [7:0]  CMD_LEN,
  // write data
  input  wire logic        WD_VALID,
  output logic             WD_READY,
  input  wire logic [7:0]  WD_DATA,
  // read data
  output logic             RD_VALID,
  input  wire logic        RD_READY,
  output logic [7:0]       RD_DATA,
  // status
  output logic             DONE,
  output logic             NACK_ERR
);
  tpi_host_state_t st;       // bus state
  tpi_step_t       step;     // byte being moved
  logic [1:0]      q;        // quarter of the bit
  logic [7:0]      qcnt;     // cycles inside the quarter
  logic [3:0]      bitn;     // bit inside the byte slot
  logic [7:0]      sh;       // shift register
  logic [7:0]      cnt;      // data bytes left
  logic            rd;       // read command
  logic [15:0]     ptr;      // register pointer
  logic            scl_low;  // pull clock low
  logic            sda_low;  // pull data low
  logic            nack;     // acknowledge bit sampled high
  logic [11:0]     por_cnt;  // power-on timer
  logic            por_ph;   // strap hold phase
  logic            rst_n_o;  // target reset drive
  logic            int_o;    // strap value
  logic            int_oe;   // strap drive
  logic            sda_s1;   // data synchroniser first stage
  logic            sda_s2;   // data synchroniser second stage
  logic            fifo_in_ready;

  wire       tick     = qcnt == 8'(QTR_CYC - 1);
  wire       rx_step  = step == S_DR;
  wire       slot0    = st == H_BIT && q == 2'h0 && bitn == 4'h0;
  wire [7:0] addr_w   = int_o ? `TPI_ADDR_ALT_W : `TPI_ADDR_PRI_W;
  wire [7:0] addr_r   = int_o ? `TPI_ADDR_ALT_R : `TPI_ADDR_PRI_R;
  // byte to send: pointer high byte goes first
  wire [7:0] src_byte = step == S_AW ? addr_w : step == S_PH ? ptr[15:8] :
                        step == S_PL ? ptr[7:0] : step == S_AR ? addr_r : WD_DATA;
  wire       tx_bit   = bitn == 4'h0 ? src_byte[7] : sh[7];
  // hold the bit clock until a data word or buffer room is there
  wire       stall    = slot0 && ((step == S_DW && !WD_VALID) || (rx_step && !fifo_in_ready));
  wire       push     = tick && st == H_BIT && q == 2'h3 && bitn == `TPI_LSB_BIT && rx_step;
  wire       last     = cnt == 8'h01;

  assign CMD_READY    = st == H_IDLE;
  assign WD_READY     = tick && slot0 && step == S_DW && !stall;
  assign BUS.m_scl_o  = 1'b0;
  assign BUS.m_scl_oe = scl_low;
  assign BUS.m_sda_o  = 1'b0;
  assign BUS.m_sda_oe = sda_low;
  assign BUS.m_rst_n  = rst_n_o;
  assign BUS.m_int_o  = int_o;
  assign BUS.m_int_oe = int_oe;

  // read bytes wait here until the user takes them
  tpi_fifo2 #(.W(8)) u_rdbuf (
    .clk       (CLK_SYS),
    .rst       (RST),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (sh),
    .out_valid (RD_VALID),
    .out_ready (RD_READY),
    .out_data  (RD_DATA)
  );

  // data line synchroniser
  always_ff @(posedge CLK_SYS) begin
    sda_s1 <= BUS.sda;
    sda_s2 <= sda_s1;
  end

  // sequencer
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st <= H_POR; step <= S_AW; q <= 2'h0; qcnt <= 8'h00; bitn <= 4'h0; sh <= 8'h00;
      cnt <= 8'h00; rd <= 1'b0; ptr <= 16'h0000; scl_low <= 1'b0; sda_low <= 1'b0;
      nack <= 1'b0; por_cnt <= 12'h000; por_ph <= 1'b0; rst_n_o <= 1'b0; int_o <= 1'b0;
      int_oe <= 1'b1; DONE <= 1'b0; NACK_ERR <= 1'b0;
    end else begin
      DONE <= 1'b0;
      qcnt <= stall ? qcnt : (tick ? 8'h00 : qcnt + 8'h01);
      unique case (st)
        // reset low with strap driven, then release reset, then the strap
        H_POR: begin
          if (!por_ph) begin
            int_o <= ADDR_ALT;
          end
          por_cnt <= por_cnt + 12'h001;
          if (por_cnt == 12'(POR_CYC - 1)) begin
            por_cnt <= 12'h000;
            por_ph  <= 1'b1;
            rst_n_o <= 1'b1;
            if (por_ph) begin
              int_oe <= 1'b0;
              st     <= H_IDLE;
            end
          end
        end
        H_IDLE: begin
          if (CMD_VALID) begin
            st <= H_START; step <= S_AW; rd <= CMD_READ; ptr <= CMD_PTR; q <= 2'h0; qcnt <= 8'h00;
            cnt <= (CMD_READ && CMD_LEN == 8'h00) ? 8'h01 : CMD_LEN;
            NACK_ERR <= 1'b0;
          end
        end
        // start or repeated start: data falls while clock is high
        H_START: if (tick) begin
          q <= q + 2'h1;
          unique case (q)
            2'h0: begin scl_low <= 1'b1; sda_low <= 1'b0; end
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= 1'b1;
            2'h3: begin scl_low <= 1'b1; st <= H_BIT; bitn <= 4'h0; end
          endcase
        end
        // stop: data rises while clock is high
        H_STOP: if (tick) begin
          q <= q + 2'h1;
          unique case (q)
            2'h0: sda_low <= 1'b1;
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= 1'b0;
            2'h3: begin st <= H_IDLE; DONE <= 1'b1; end
          endcase
        end
        // one of nine bit slots; data moves only in clock-low quarters
        // a stall freezes the slot, so no word is taken without its handshake
        H_BIT: if (tick && !stall) begin
          q <= q + 2'h1;
          unique case (q)
            2'h0: begin
              if (bitn == 4'h0 && !rx_step) begin
                sh <= src_byte;
              end
              if (bitn == `TPI_ACK_BIT) begin
                sda_low <= rx_step && !last;
              end else begin
                sda_low <= !rx_step && !tx_bit;
              end
            end
            2'h1: scl_low <= 1'b0;
            2'h2: begin
              if (bitn == `TPI_ACK_BIT) begin
                nack <= sda_s2;
              end else begin
                sh <= {sh[6:0], sda_s2};
              end
            end
            2'h3: begin
              scl_low <= 1'b1;
              if (bitn != `TPI_ACK_BIT) begin
                bitn <= bitn + 4'h1;
              end else begin
                bitn <= 4'h0;
                if (!rx_step && nack) begin
                  NACK_ERR <= 1'b1;
                  st       <= H_STOP;
                end else begin
                  unique case (step)
                    S_AW: step <= S_PH;
                    S_PH: step <= S_PL;
                    S_PL: begin
                      if (rd) begin
                        step <= S_AR;
                        st   <= H_START;
                      end else if (cnt == 8'h00) begin
                        st <= H_STOP;
                      end else begin
                        step <= S_DW;
                      end
                    end
                    S_AR: step <= S_DR;
                    S_DW, S_DR: begin
                      cnt <= cnt - 8'h01;
                      if (last) begin
                        st <= H_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      endcase
    end
  end
endmodule

// ==== bench/tpi_properties.sv ====
// tpi_properties.sv: checks of the target's data drive on the two-wire bus.
// assumes CLK_SYS oversamples scl and sda, which the master makes from CLK_SYS.
`timescale 1ns/1ps
module tpi_properties (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // bus
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_oe,
  input wire logic m_rst_n,
  input wire logic int_lvl
);
  logic       scl_q, sda_q;  // last levels
  logic       rstn_q, alt;   // reset line last level, strap caught at its release
  logic       first, rd;     // address byte next, read transfer
  logic       mute;          // target must stay off
  logic [3:0] bit_n;         // pulse index in slot
  logic [7:0] sh;            // received bits
  wire rise  = scl & ~scl_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop  = scl & scl_q & ~sda_q & sda;
  wire ack8  = rise & (bit_n == 4'h8);
  wire hit   = (sh[7:1] == (alt ? 7'h14 : 7'h5d));
  // frame tracking; start clears, stop or refusal mutes
  always_ff @(posedge CLK_SYS) begin
    scl_q <= scl;
    sda_q <= sda;
    rstn_q <= m_rst_n;
    if (m_rst_n & ~rstn_q) alt <= int_lvl;
    if (RST || start) begin
      bit_n <= 4'h0;
      first <= 1'b1;
      mute  <= 1'b0;
    end else begin
      mute <= mute | stop | (ack8 & ((first & ~hit) | (~first & rd & sda)));
      if (rise) bit_n <= ack8 ? 4'h0 : bit_n + 4'h1;
      if (rise & ~bit_n[3]) sh <= {sh[6:0], sda};
      if (ack8 & first) rd <= sh[0];
      if (ack8) first <= 1'b0;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_ack_match; ack8 && first && d_sda_oe |-> hit; endproperty
  property p_ack_given; ack8 && first && hit |-> d_sda_oe; endproperty
  property p_addr_quiet; rise && first && !bit_n[3] |-> !d_sda_oe; endproperty
  property p_hold_high; $past(scl) && scl |-> $stable(d_sda_oe); endproperty
  property p_mute; mute |-> !d_sda_oe; endproperty
  property p_wr_ack; ack8 && !first && !rd && !mute |-> d_sda_oe; endproperty
  property p_rd_release; ack8 && !first && rd |-> !d_sda_oe; endproperty
  property p_por_quiet; !m_rst_n [*5] |-> !d_sda_oe; endproperty
  a_ack_match: assert property (p_ack_match) else $error("ack to foreign address");
  a_ack_given: assert property (p_ack_given) else $error("own address not acked");
  a_addr_quiet: assert property (p_addr_quiet) else $error("drive in address bits");
  a_hold_high: assert property (p_hold_high) else $error("data moved with clock high");
  a_mute: assert property (p_mute) else $error("drive while released");
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acked");
  a_rd_release: assert property (p_rd_release) else $error("drive in master ack");
  a_por_quiet: assert property (p_por_quiet) else $error("drive in target reset");
  c_write: cover property (ack8 && !first && !rd && d_sda_oe);
  c_nack: cover property (ack8 && !first && rd && sda);
  c_stop: cover property (stop);
  c_alt: cover property (ack8 && first && alt && d_sda_oe);
endmodule

// ==== bench/touch_ctrl_i2c_register_access_tb.sv ====
// touch_ctrl_i2c_register_access_tb.sv: master and target ends joined on one bus.
// assumes the master divides CLK_SYS for the bus and the target runs on LINK_CLK.
`timescale 1ns/1ps
module touch_ctrl_i2c_register_access_tb;
  logic        clk_sys = 1'b0, link_clk = 1'b0, rst = 1'b1, addr_alt = 1'b0;
  logic        cmd_valid = 1'b0, cmd_read = 1'b0, wd_valid = 1'b0, rd_ready = 1'b0;
  logic [15:0] cmd_ptr = 16'h0000, wr_addr;
  logic [7:0]  cmd_len = 8'h00, wd_data = 8'h00, rd_data, wr_data;
  logic        cmd_ready, wd_ready, rd_valid, done, nack_err, wr_strobe, alt_sel, busy;
  logic [7:0]  pat [3] = '{8'h5a, 8'ha5, 8'h00};  // bytes written then read back
  logic [15:0] seen_addr [$];                     // captured write notices
  logic [7:0]  seen_data [$];
  int          fail_count = 0, checks = 0;
  tpi_if bus ();
  tpi_host #(.QTR_CYC(8), .POR_CYC(8)) u_tpi_host (.CLK_SYS(clk_sys), .RST(rst), .BUS(bus.host),
    .ADDR_ALT(addr_alt), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_READ(cmd_read),
    .CMD_PTR(cmd_ptr), .CMD_LEN(cmd_len), .WD_VALID(wd_valid), .WD_READY(wd_ready),
    .WD_DATA(wd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
    .DONE(done), .NACK_ERR(nack_err));
  tpi_device u_tpi_device (.CLK_SYS(clk_sys), .RST(rst), .LINK_CLK(link_clk), .BUS(bus.dev),
    .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .ADDR_ALT_SEL(alt_sel),
    .LINK_BUSY(busy));
  tpi_properties u_tpi_properties (.CLK_SYS(clk_sys), .RST(rst), .scl(bus.scl),
    .sda(bus.sda), .d_sda_oe(bus.d_sda_oe), .m_rst_n(bus.m_rst_n), .int_lvl(bus.int_lvl));
  initial forever #20 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // log every byte the target reports written
  always @(negedge clk_sys) begin
    if (wr_strobe === 1'b1) begin
      seen_addr.push_back(wr_addr);
      seen_data.push_back(wr_data);
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one command: feeds write bytes, pops read bytes after a stall
  task automatic run(input logic rd, input logic [15:0] ptr, input logic [7:0] len, input int stall);
    int   n, wi, ri;
    logic adv, bz;
    wi = 0;
    ri = 0;
    adv = 1'b0;
    bz = 1'b0;
    for (n = 0; n < 2000 && cmd_ready !== 1'b1; n++) @(negedge clk_sys);
    if (n == 2000) begin
      fail_count++;
      stop_test();
    end
    cmd_read = rd;
    cmd_ptr = ptr;
    cmd_len = len;
    cmd_valid = 1'b1;
    wd_valid = ~rd;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (n = 0; n < 20000; n++) begin
      if (adv) wi++;
      wd_data = pat[wi % 3];
      adv = (wd_ready === 1'b1);
      bz |= (busy === 1'b1);
      rd_ready = (n >= stall) && (rd_valid === 1'b1);
      if (rd_ready) begin
        check("read byte", {8'h00, rd_data}, {8'h00, pat[ri % 3]});
        ri++;
      end
      if (done === 1'b1 && rd_valid !== 1'b1) break;
      @(negedge clk_sys);
    end
    rd_ready = 1'b0;
    wd_valid = 1'b0;
    if (n == 20000) begin
      fail_count++;
      stop_test();
    end
    check("busy seen", {15'h0000, bz}, 16'h0001);
    check("bytes moved", 16'(rd ? ri : wi), {8'h00, len});
    check("target refused", {15'h0000, nack_err}, 16'h0000);
  endtask
  // three bytes across a low-byte boundary of the pointer
  task automatic t_write;
    run(1'b0, 16'h01fe, 8'h03, 0);
    check("notices", 16'(seen_addr.size()), 16'h0003);
    foreach (seen_addr[i]) begin
      check("notice address", seen_addr[i], 16'h01fe + 16'(i));
      check("notice data", {8'h00, seen_data[i]}, {8'h00, pat[i % 3]});
    end
  endtask
  // read back with the receiver stalled until the buffer refuses
  task automatic t_read;
    run(1'b1, 16'h01fe, 8'h03, 3000);
    check("strap", {15'h0000, alt_sel}, 16'h0000);
  endtask
  // second reset with the alternate pair strapped; bytes survive and read back
  task automatic t_alt;
    addr_alt = 1'b1;
    rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    run(1'b1, 16'h01fe, 8'h03, 0);
    check("alt strap", {15'h0000, alt_sel}, 16'h0001);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    t_write();
    t_read();
    t_alt();
    stop_test();
  end
endmodule
